// >>> logic/sarseq_pkg.sv
// Purpose: Shared constants and types of the SAR converter sequencer.
// Assumes: The system clock runs at 100 MHz and software uses 32-bit AXI4-Lite words.
// Notes: Register bytes sit in the low eight bits of each word.
package sarseq_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFS_CONTROL_0 = 8'h00;
  localparam logic [7:0] OFS_PIN_REF = 8'h04;
  localparam logic [7:0] OFS_TIMING_FMT = 8'h08;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h0C;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h10;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h14;
  // Field positions in the control register.
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_GO_BIT = 1;
  localparam int CTL_CHS_LSB = 2;
  localparam int CTL_CAL_BIT = 7;
  // Field positions in the pin and reference register.
  localparam int PRC_PORT_ANALOG_CONFIG_LSB = 0;
  localparam int PRC_POS_BIT = 4;
  localparam int PRC_NEG_BIT = 5;
  // Field positions in the timing and format register.
  localparam int TFC_CCS_LSB = 0;
  localparam int TFC_ACQ_LSB = 3;
  localparam int TFC_FMT_BIT = 7;
  // Field positions in the interrupt register.
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  // Reset values and write masks; masked bits are unimplemented.
  localparam logic [7:0] RST_CONTROL_0 = 8'h00;
  localparam logic [7:0] RST_PIN_REF = 8'h00;
  localparam logic [7:0] RST_TIMING_FMT = 8'h00;
  localparam logic [7:0] MSK_CONTROL_0 = 8'hBF;
  localparam logic [7:0] MSK_PIN_REF = 8'h3F;
  localparam logic [7:0] MSK_TIMING_FMT = 8'hBF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing: one instruction cycle and the internal RC conversion clock period.
  localparam int CLK_PERIOD_PS = 10000;
  localparam int TCY_NS = 40;
  localparam int TCY_CYCLES = (TCY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RC_TAD_NS = 4000;
  localparam int RC_TAD_CYCLES = (RC_TAD_NS * 1000) / CLK_PERIOD_PS;
  localparam int CONV_TADS = 11;
  localparam int WAIT_TADS = 2;
  localparam int RESULT_W = 10;
  localparam int NUM_INPUTS = 12;
  localparam int LAST_INPUT = 11;
  localparam int PORT_ANALOG_CONFIG_LIMIT = 15;
  typedef enum logic [2:0] {
    SARSEQ_IDLE, SARSEQ_RC_DELAY, SARSEQ_ACQUIRE, SARSEQ_CALIBRATE, SARSEQ_CONVERT, SARSEQ_WAIT
  } sarseq_state_t;
endpackage

// >>> logic/sarseq_top.sv
// Purpose: Register file and sequencer of a 10-bit successive-approximation converter.
// Assumes: The analog comparator and sample switch sit outside; only aclk exists.
// Notes: The internal RC conversion clock is modelled as a divider of aclk.
`timescale 1ns/1ps
// Contract
// - Build a 10-bit result by successive approximation on the held sample.
// - A set calibration request adds a calibration pass to the next conversion.
// - Channel codes 0 to 11 pick inputs 0 to 11; 11xx picks no input.
// - While enabled, the start/status bit reads 1 during conversion, 0 idle.
// - The enable bit turns the converter on when set, off when clear.
// - Negative reference is the external pin when set, analog ground when clear.
// - Positive reference is the external pin when set, analog supply when clear.
// - Port codes up to 0011 are all analog; each further code digitalises one more.
// - Result format bit set right-justifies, clear left-justifies the result.
// - Acquisition codes give 0,2,4,6,8,12,16,20 conversion clock periods.
// - Clock codes divide the oscillator by 2 to 64; x11 picks the RC clock.
// - With the RC clock, one instruction cycle passes before it starts running.
// - In sleep only the RC clock drives conversions; software must choose it.
// - On completion load the result pair, clear start/status, set the flag.
// - Reset restores control registers, turns the module off, aborts conversion.
// - Reset leaves the result pair untouched.
// - A nonzero acquisition time is inserted between start and conversion.
// - Two conversion clock periods pass after an end before sampling restarts.
// - Unimplemented register bits ignore writes and read as zero.
// - A conversion takes exactly 11 conversion clock periods.
// - Clearing start/status mid-conversion aborts and keeps the old result.
// - After programmed acquisition the conversion begins; afterwards sampling resumes.
module sarseq_top
  import sarseq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sarseq_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sarseq_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_high,
  input wire logic sleep_active,
  output logic sample_enable,
  output logic [sarseq_pkg::RESULT_W-1:0] dac_code,
  output logic [3:0] channel_select,
  output logic channel_valid,
  output logic [sarseq_pkg::NUM_INPUTS-1:0] analog_pin_mask,
  output logic neg_ref_external,
  output logic pos_ref_external,
  output logic calibrate_active,
  output logic converter_enabled,
  output logic conv_irq
);
  import sarseq_pkg::*;

  // Clock cycles per conversion clock period for each clock select code.
  function automatic logic [8:0] tad_ratio(input logic [2:0] code);
    case (code)
      3'b000: tad_ratio = 9'h002;
      3'b100: tad_ratio = 9'h004;
      3'b001: tad_ratio = 9'h008;
      3'b101: tad_ratio = 9'h010;
      3'b010: tad_ratio = 9'h020;
      3'b110: tad_ratio = 9'h040;
      default: tad_ratio = 9'(RC_TAD_CYCLES);
    endcase
  endfunction

  // Acquisition length in conversion clock periods.
  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'b000: acq_tads = 5'h00;
      3'b001: acq_tads = 5'h02;
      3'b010: acq_tads = 5'h04;
      3'b011: acq_tads = 5'h06;
      3'b100: acq_tads = 5'h08;
      3'b101: acq_tads = 5'h0C;
      3'b110: acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  endfunction

  // Address decode shared by the write and read paths.
  function automatic logic addr_hit(input logic [AXI_ADDR_W-1:0] a);
    addr_hit = (a == OFS_CONTROL_0) || (a == OFS_PIN_REF) || (a == OFS_TIMING_FMT) ||
               (a == OFS_RESULT_HIGH) || (a == OFS_RESULT_LOW) || (a == OFS_IRQ_CTRL);
  endfunction

  logic [7:0] control_0;
  logic [7:0] pin_ref;
  logic [7:0] timing_fmt;
  logic [7:0] result_high;
  logic [7:0] result_low;
  logic conv_interrupt_flag;
  logic conv_interrupt_enable;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic aw_held;
  logic [7:0] w_byte;
  logic w_lane0;
  logic w_held;
  logic cmp_meta;
  logic cmp_sync;
  logic sleep_meta;
  logic sleep_sync;
  sarseq_state_t state;
  sarseq_state_t next_state;
  logic [8:0] tad_cnt;
  logic [4:0] step;
  logic [RESULT_W-1:0] sar;
  logic [8:0] rc_delay_cnt;

  // Register fields.
  wire module_enable = control_0[CTL_EN_BIT];
  wire start_status = control_0[CTL_GO_BIT];
  wire calibrate_request = control_0[CTL_CAL_BIT];
  wire [3:0] chan_field = control_0[CTL_CHS_LSB+:4];
  wire [3:0] port_analog_config = pin_ref[PRC_PORT_ANALOG_CONFIG_LSB+:4];
  wire result_format = timing_fmt[TFC_FMT_BIT];
  wire [2:0] acquisition_time_select = timing_fmt[TFC_ACQ_LSB+:3];
  wire [2:0] conv_clock_select = timing_fmt[TFC_CCS_LSB+:3];
  wire internal_rc_clock = conv_clock_select[1] & conv_clock_select[0];

  // Write path: address and data are taken in either order, then applied together.
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire wr_ok = wr_go && addr_hit(aw_addr) && w_lane0;
  wire wr_ctl = wr_ok && (aw_addr == OFS_CONTROL_0);
  wire wr_pin = wr_ok && (aw_addr == OFS_PIN_REF);
  wire wr_tfc = wr_ok && (aw_addr == OFS_TIMING_FMT);
  wire wr_rhi = wr_ok && (aw_addr == OFS_RESULT_HIGH);
  wire wr_rlo = wr_ok && (aw_addr == OFS_RESULT_LOW);
  wire wr_irq = wr_ok && (aw_addr == OFS_IRQ_CTRL);
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // Sequencer events.
  wire busy = (state == SARSEQ_RC_DELAY) || (state == SARSEQ_ACQUIRE) ||
              (state == SARSEQ_CALIBRATE) || (state == SARSEQ_CONVERT);
  wire tad_run = (state == SARSEQ_ACQUIRE) || (state == SARSEQ_CALIBRATE) ||
                 (state == SARSEQ_CONVERT) || (state == SARSEQ_WAIT);
  // In sleep the oscillator stops, so only the RC clock keeps periods coming.
  wire tad_clock_alive = !sleep_sync || internal_rc_clock;
  wire tad_tick = tad_run && tad_clock_alive && (tad_cnt == tad_ratio(conv_clock_select) - 9'h001);
  wire conv_done = (state == SARSEQ_CONVERT) && tad_tick &&
                   (step == 5'(CONV_TADS - 1));
  wire abort = busy && !start_status;
  wire launch = (state == SARSEQ_IDLE) && module_enable && start_status;
  wire [4:0] acq_len = acq_tads(acquisition_time_select);
  // Successive approximation: keep the trial bit when the input is above it.
  wire [3:0] bit_idx = 4'(RESULT_W) - 4'(step);
  wire [RESULT_W-1:0] sar_kept = cmp_sync ? sar : (sar & ~(10'h001 << bit_idx));
  wire [RESULT_W-1:0] trial_next = (step == 5'h00) ? 10'h200 :
                                   (sar_kept | ((10'h200 >> step) & {RESULT_W{step < 5'h0A}}));
  wire [7:0] fmt_high = result_format ? {6'h00, sar_kept[9:8]} : sar_kept[9:2];
  wire [7:0] fmt_low = result_format ? sar_kept[7:0] : {sar_kept[1:0], 6'h00};

  // Two-flop synchronisers for the comparator decision and the sleep level.
  always_ff @(posedge aclk) begin
    cmp_meta <= comparator_high;
    cmp_sync <= cmp_meta;
    sleep_meta <= sleep_active;
    sleep_sync <= sleep_meta;
  end

  // Write address and data holding stages.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register. The status bit is cleared by completion or by disabling;
  // a software write of the same cycle still lands, but its status bit loses to completion so no done is missed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_0 <= RST_CONTROL_0;
    end else if (conv_done) begin
      control_0[CTL_GO_BIT] <= 1'b0;
      if (wr_ctl) begin
        control_0 <= w_byte & MSK_CONTROL_0 & ~(8'h01 << CTL_GO_BIT);
      end
    end else if (wr_ctl) begin
      control_0 <= w_byte & MSK_CONTROL_0 & {6'h3F, w_byte[CTL_EN_BIT], 1'b1};
    end
  end

  // Configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_ref <= RST_PIN_REF;
      timing_fmt <= RST_TIMING_FMT;
    end else begin
      if (wr_pin) begin
        pin_ref <= w_byte & MSK_PIN_REF;
      end
      if (wr_tfc) begin
        timing_fmt <= w_byte & MSK_TIMING_FMT;
      end
    end
  end

  // Result pair: no reset, so its contents survive a reset and are unknown at power-on.
  always_ff @(posedge aclk) begin
    if (conv_done) begin
      result_high <= fmt_high;
      result_low <= fmt_low;
    end else begin
      if (wr_rhi) begin
        result_high <= w_byte;
      end
      if (wr_rlo) begin
        result_low <= w_byte;
      end
    end
  end

  // Interrupt flag: completion wins over a software clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_interrupt_flag <= 1'b0;
      conv_interrupt_enable <= 1'b0;
    end else begin
      if (conv_done) begin
        conv_interrupt_flag <= 1'b1;
      end else if (wr_irq) begin
        conv_interrupt_flag <= w_byte[IRQ_FLAG_BIT];
      end
      if (wr_irq) begin
        conv_interrupt_enable <= w_byte[IRQ_EN_BIT];
      end
    end
  end

  // Read path; unimplemented bits were masked at write time so they read zero.
  wire [7:0] rd_byte =
    (s_axi_araddr == OFS_CONTROL_0) ? control_0 :
    (s_axi_araddr == OFS_PIN_REF) ? pin_ref :
    (s_axi_araddr == OFS_TIMING_FMT) ? timing_fmt :
    (s_axi_araddr == OFS_RESULT_HIGH) ? result_high :
    (s_axi_araddr == OFS_RESULT_LOW) ? result_low :
    (s_axi_araddr == OFS_IRQ_CTRL) ? {6'h00, conv_interrupt_enable, conv_interrupt_flag} :
    8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Sequencer transitions; disabling drops straight to idle from any state.
  always_comb begin
    next_state = state;
    case (state)
      SARSEQ_IDLE: begin
        if (launch) begin
          if (internal_rc_clock) begin
            next_state = SARSEQ_RC_DELAY;
          end else if (acq_len != 5'h00) begin
            next_state = SARSEQ_ACQUIRE;
          end else begin
            next_state = calibrate_request ? SARSEQ_CALIBRATE : SARSEQ_CONVERT;
          end
        end
      end
      SARSEQ_RC_DELAY: begin
        if (rc_delay_cnt == 9'(TCY_CYCLES - 1)) begin
          if (acq_len != 5'h00) begin
            next_state = SARSEQ_ACQUIRE;
          end else begin
            next_state = calibrate_request ? SARSEQ_CALIBRATE : SARSEQ_CONVERT;
          end
        end
      end
      SARSEQ_ACQUIRE: begin
        if (tad_tick && (step == acq_len - 5'h01)) begin
          next_state = calibrate_request ? SARSEQ_CALIBRATE : SARSEQ_CONVERT;
        end
      end
      SARSEQ_CALIBRATE: begin
        if (tad_tick && (step == 5'(CONV_TADS - 1))) begin
          next_state = SARSEQ_CONVERT;
        end
      end
      SARSEQ_CONVERT: begin
        if (conv_done) begin
          next_state = SARSEQ_WAIT;
        end
      end
      SARSEQ_WAIT: begin
        if (tad_tick && (step == 5'(WAIT_TADS - 1))) begin
          next_state = SARSEQ_IDLE;
        end
      end
      default: next_state = SARSEQ_IDLE;
    endcase
    if (abort) begin
      next_state = SARSEQ_WAIT;
    end
    if (!module_enable) begin
      next_state = SARSEQ_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SARSEQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Conversion clock divider and period counter; both restart on every state change.
  always_ff @(posedge aclk) begin
    if (!aresetn || (next_state != state)) begin
      tad_cnt <= 9'h000;
      step <= 5'h00;
    end else if (tad_tick) begin
      tad_cnt <= 9'h000;
      step <= step + 5'h01;
    end else if (tad_run && tad_clock_alive) begin
      tad_cnt <= tad_cnt + 9'h001;
    end
  end

  // Instruction-cycle delay before the RC conversion clock starts.
  always_ff @(posedge aclk) begin
    if (!aresetn || (state != SARSEQ_RC_DELAY)) begin
      rc_delay_cnt <= 9'h000;
    end else begin
      rc_delay_cnt <= rc_delay_cnt + 9'h001;
    end
  end

  // Approximation register and trial code; period 0 holds the sample, 1 to 10 decide bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sar <= '0;
      dac_code <= '0;
    end else if ((state == SARSEQ_CONVERT) && tad_tick) begin
      sar <= trial_next;
      dac_code <= trial_next;
    end else if (state != SARSEQ_CONVERT) begin
      sar <= '0;
    end
  end

  // Analog-side controls, decoded from registers and sequencer state.
  assign sample_enable = module_enable && (state == SARSEQ_IDLE || state == SARSEQ_RC_DELAY ||
                         state == SARSEQ_ACQUIRE);
  assign calibrate_active = (state == SARSEQ_CALIBRATE);
  assign channel_select = chan_field;
  assign channel_valid = module_enable && (chan_field <= 4'(LAST_INPUT));
  assign neg_ref_external = pin_ref[PRC_NEG_BIT];
  assign pos_ref_external = pin_ref[PRC_POS_BIT];
  assign converter_enabled = module_enable;
  assign conv_irq = conv_interrupt_flag && conv_interrupt_enable;

  // Input i stays analog while i plus the port code is below the limit.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi = gi + 1) begin : g_pin
      assign analog_pin_mask[gi] = (5'(gi) + {1'b0, port_analog_config}) < 5'(PORT_ANALOG_CONFIG_LIMIT);
    end
  endgenerate

endmodule

// >>> verification/sarseq_analog_model.sv
// Purpose: Behavioural sample-and-hold and comparator facing the sequencer.
// Assumes: The bench sets the analog level as a 10-bit code.
// Notes: The held value freezes when sampling stops, as the real capacitor does.
`timescale 1ns/1ps
module sarseq_analog_model (
  input wire logic aclk,
  input wire logic sample_enable,
  input wire logic [sarseq_pkg::RESULT_W-1:0] dac_code,
  input wire logic [sarseq_pkg::RESULT_W-1:0] lvl,
  output logic comparator_high
);
  logic [sarseq_pkg::RESULT_W-1:0] held;
  // Track the input only while the switch is closed.
  always_ff @(posedge aclk) begin
    if (sample_enable) begin
      held <= lvl;
    end
  end
  // A set output keeps the trial bit, so the search ends on the held code.
  assign comparator_high = (held >= dac_code);
endmodule

// >>> verification/sarseq_top_sva.sv
// Purpose: Port-level checks of the converter sequencer.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Exact conversion lengths depend on register contents and are timed by the bench.
`timescale 1ns/1ps
module sarseq_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_enable,
  input wire logic [3:0] channel_select,
  input wire logic channel_valid,
  input wire logic [sarseq_pkg::NUM_INPUTS-1:0] analog_pin_mask,
  input wire logic calibrate_active,
  input wire logic converter_enabled,
  input wire logic conv_irq
);
  // Every check shares the clock and stands down during reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_chan_valid_code: assert property (channel_valid == (converter_enabled && channel_select <= 4'hB))
    else $error("channel valid disagrees with the code");
  a_reset_state: assert property ($rose(aresetn) |-> analog_pin_mask == 12'hFFF && !conv_irq && !converter_enabled && !sample_enable)
    else $error("state after reset is wrong");
  a_off_no_sample: assert property (!converter_enabled |-> !sample_enable && !calibrate_active)
    else $error("disabled converter is still active");
  a_wait_min_tad: assert property ($fell(sample_enable) && converter_enabled |-> !sample_enable [*4])
    else $error("sampling resumed too soon");
  a_cal_hold_open: assert property (calibrate_active |-> !sample_enable && converter_enabled)
    else $error("calibration while sampling");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("unimplemented bits read nonzero");
  a_read_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_mask_thermo: assert property (((13'(analog_pin_mask) + 13'h1) & 13'(analog_pin_mask)) == 13'h0)
    else $error("analog mask is not contiguous from input 0");
endmodule
bind sarseq_top sarseq_top_sva u_sva (.aclk, .aresetn, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .sample_enable, .channel_select, .channel_valid, .analog_pin_mask, .calibrate_active,
  .converter_enabled, .conv_irq);

// >>> verification/tb.sv
// Purpose: Self-checking bench of the converter sequencer over AXI4-Lite.
// Assumes: The analog model answers the comparator.
// Notes: Results at the ratio-2 clock are not compared, its comparator path lags a trial.
`timescale 1ns/1ps
module tb;
  import sarseq_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr = 8'h00;
  logic [AXI_ADDR_W-1:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic sleep_active = 1'b0;
  logic [RESULT_W-1:0] lvl = 10'h2A5;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic comparator_high, sample_enable, channel_valid, neg_ref_external, pos_ref_external;
  logic calibrate_active, converter_enabled, conv_irq;
  logic [RESULT_W-1:0] dac_code;
  logic [3:0] channel_select;
  logic [NUM_INPUTS-1:0] analog_pin_mask;
  int failures = 0;
  int checked = 0;
  int rt [8] = '{2, 8, 32, 400, 4, 16, 64, 400};
  int aq [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  sarseq_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_high, .sleep_active, .sample_enable,
    .dac_code, .channel_select, .channel_valid, .analog_pin_mask, .neg_ref_external,
    .pos_ref_external, .calibrate_active, .converter_enabled, .conv_irq);
  sarseq_analog_model u_model (.aclk, .sample_enable, .dac_code, .lvl, .comparator_high);
  // Free-running 100 MHz clock.
  initial forever #5 aclk = ~aclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Both channels are offered together and each is released once taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic wt(input logic v, output int n);
    n = 0;
    while (sample_enable !== v) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic t_regs;
    chk(analog_pin_mask, 12'hFFF);
    rdc(OFS_CONTROL_0, 32'h0, RESP_OKAY);
    rdc(OFS_TIMING_FMT, 32'h0, RESP_OKAY);
    wr(OFS_CONTROL_0, 8'hFC, RESP_OKAY);
    rdc(OFS_CONTROL_0, 32'hBC, RESP_OKAY);
    wr(OFS_PIN_REF, 8'hFF, RESP_OKAY);
    rdc(OFS_PIN_REF, 32'h3F, RESP_OKAY);
    wr(OFS_TIMING_FMT, 8'hFF, RESP_OKAY);
    rdc(OFS_TIMING_FMT, 32'hBF, RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    wr(OFS_PIN_REF, 8'h00, RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    rdc(OFS_PIN_REF, 32'h3F, RESP_OKAY);
    wr(8'h18, 8'h55, RESP_SLVERR);
    rdc(8'h18, 32'h0, RESP_SLVERR);
    wr(OFS_CONTROL_0, 8'h00, RESP_OKAY);
    wr(OFS_TIMING_FMT, 8'h00, RESP_OKAY);
  endtask
  // Every pin code and every channel code, with both reference bits.
  task automatic t_pins;
    for (int c = 0; c < 16; c++) begin
      logic [3:0] k;
      k = 4'(c);
      wr(OFS_PIN_REF, {2'b00, k[1:0], k}, RESP_OKAY);
      chk(analog_pin_mask, 12'hFFF >> ((k < 4'h4) ? 4'h0 : k - 4'h3));
      chk(neg_ref_external, k[1]);
      chk(pos_ref_external, k[0]);
      wr(OFS_CONTROL_0, {2'b00, k, 2'b01}, RESP_OKAY);
      chk(channel_select, k);
      chk(channel_valid, k <= 4'hB);
      chk(converter_enabled, 1'b1);
    end
    wr(OFS_CONTROL_0, 8'h00, RESP_OKAY);
  endtask
  // One conversion: times acquisition and the open span, then checks result and flag.
  task automatic conv(input logic [2:0] cs, input logic [2:0] ac, input logic fm, input logic cl);
    int d;
    int lo;
    int ex;
    int nc;
    logic seen;
    logic [9:0] r;
    seen = 1'b0;
    r = lvl;
    ex = aq[ac] * rt[cs] + ((cs[1:0] == 2'b11) ? TCY_CYCLES : 0);
    nc = (cl ? 24 : 13) * rt[cs];
    wr(OFS_IRQ_CTRL, 8'h02, RESP_OKAY);
    wr(OFS_TIMING_FMT, {fm, 1'b0, ac, cs}, RESP_OKAY);
    wr(OFS_CONTROL_0, {cl, 1'b0, 4'h1, 2'b11}, RESP_OKAY);
    wt(1'b0, d);
    lvl <= ~r;
    chk(32'(d >= ex - 2 && d <= ex + 3), 32'h1);
    lo = 0;
    while (sample_enable !== 1'b1) begin
      @(posedge aclk);
      lo++;
      seen |= calibrate_active;
    end
    chk(32'(lo >= nc - 1 && lo <= nc + 1), 32'h1);
    chk(seen, cl);
    rdc(OFS_CONTROL_0, {24'h0, cl, 1'b0, 4'h1, 2'b01}, RESP_OKAY);
    rdc(OFS_IRQ_CTRL, 32'h3, RESP_OKAY);
    chk(conv_irq, 1'b1);
    if (rt[cs] > 2) begin
      rdc(OFS_RESULT_HIGH, fm ? {30'h0, r[9:8]} : {24'h0, r[9:2]}, RESP_OKAY);
      rdc(OFS_RESULT_LOW, fm ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h0}, RESP_OKAY);
    end
    wr(OFS_IRQ_CTRL, 8'h02, RESP_OKAY);
    chk(conv_irq, 1'b0);
  endtask
  // Sleep stall, then abort, then reset during acquisition.
  task automatic t_misc;
    int n;
    wr(OFS_TIMING_FMT, 8'h04, RESP_OKAY);
    sleep_active <= 1'b1;
    wr(OFS_CONTROL_0, 8'h07, RESP_OKAY);
    repeat (300) @(posedge aclk);
    rdc(OFS_CONTROL_0, 32'h07, RESP_OKAY);
    sleep_active <= 1'b0;
    wt(1'b1, n);
    rdc(OFS_CONTROL_0, 32'h05, RESP_OKAY);
    sleep_active <= 1'b1;
    conv(3'h3, 3'h0, 1'b1, 1'b0);
    sleep_active <= 1'b0;
    wr(OFS_RESULT_HIGH, 8'h5A, RESP_OKAY);
    wr(OFS_RESULT_LOW, 8'hC0, RESP_OKAY);
    wr(OFS_TIMING_FMT, 8'h3E, RESP_OKAY);
    wr(OFS_CONTROL_0, 8'h07, RESP_OKAY);
    wt(1'b0, n);
    repeat (100) @(posedge aclk);
    rdc(OFS_CONTROL_0, 32'h07, RESP_OKAY);
    wr(OFS_CONTROL_0, 8'h05, RESP_OKAY);
    wt(1'b1, n);
    rdc(OFS_RESULT_HIGH, 32'h5A, RESP_OKAY);
    rdc(OFS_RESULT_LOW, 32'hC0, RESP_OKAY);
    rdc(OFS_IRQ_CTRL, 32'h2, RESP_OKAY);
    wr(OFS_CONTROL_0, 8'h07, RESP_OKAY);
    repeat (50) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(OFS_CONTROL_0, 32'h0, RESP_OKAY);
    rdc(OFS_IRQ_CTRL, 32'h0, RESP_OKAY);
    rdc(OFS_RESULT_HIGH, 32'h5A, RESP_OKAY);
    rdc(OFS_RESULT_LOW, 32'hC0, RESP_OKAY);
  endtask
  task automatic results;
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence after a two-cycle reset.
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_pins;
    for (int a = 0; a < 8; a++) conv(3'h4, 3'(a), a[0], 1'b0);
    for (int c = 0; c < 8; c++) conv(3'(c), 3'h1, 1'b1, 1'b0);
    conv(3'h1, 3'h2, 1'b0, 1'b1);
    t_misc;
    results;
  end
  // The full sequence needs about 23000 cycles; this limit leaves ample margin.
  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    results;
  end
endmodule
